// ===== ssof_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssof_defs.svh"
module ssof_top
    import ssof_pkg::*;
#(
    parameter int TICK_CYCLES = `SSOF_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic internal_position_mode,
    input wire logic origin_sensor_input,
    input wire logic homing_cmd,
    input wire logic position_overflow,
    input wire logic overload_active,
    input wire logic [15:0] overload_permit_ms,
    input wire logic [7:0] overload_caution_percent,
    input wire logic reverse_limit_err,
    input wire logic forward_limit_err,
    input wire logic emergency_stop,
    input wire logic serial_link_err,
    input wire logic undervoltage,
    input wire logic other_fault,
    input wire logic alarm_reset,
    input wire logic [7:0] out_func_sel,
    output logic homing_done_out,
    output logic overload_caution_out,
    output logic servo_caution_out,
    output logic position_cmd_overrun_out,
    output logic servo_fault_out,
    output logic [7:0] overload_alarm_code,
    output logic func_out
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_m_r;
    logic rst_s_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_r <= 1'b0;
            rst_s_n <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_s_n <= rst_m_r;
        end
    end

    // ----------------------------------------
    // overload timer
    // ----------------------------------------
    ssof_ovl_if ovl ();

    assign ovl.overload_active = overload_active;
    assign ovl.permit_ms = overload_permit_ms;
    assign ovl.percent = overload_caution_percent;

    ssof_ovl_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
        .clk(clk),
        .rst_s_n(rst_s_n),
        .ovl(ovl.timer)
    );

    // ----------------------------------------
    // output function select
    // ----------------------------------------
    function automatic logic ssof_pick(input logic [7:0] code, input logic home,
                                       input logic caut, input logic warn,
                                       input logic overrun, input logic fault);
        unique case (code)
            `SSOF_FN_HOME: return home;
            `SSOF_FN_CAUTION: return caut;
            `SSOF_FN_WARN: return warn;
            `SSOF_FN_OVERRUN: return overrun;
            `SSOF_FN_FAULT: return fault;
            default: return 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // homing state
    // ----------------------------------------
    ssof_home_type home_r;
    ssof_home_type home_nxt;
    logic origin_d_r;
    logic origin_seen;

    assign origin_seen = origin_sensor_input && !origin_d_r;

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            origin_d_r <= 1'b0;
        end else begin
            origin_d_r <= origin_sensor_input;
        end
    end

    always_comb begin
        home_nxt = home_r;
        unique case (home_r)
            SSOF_HM_NOT: begin
                if (homing_cmd && internal_position_mode) begin
                    home_nxt = SSOF_HM_RUN;
                end else if (origin_seen) begin
                    home_nxt = SSOF_HM_DONE;
                end
            end
            SSOF_HM_RUN: begin
                // a standing command keeps the run going, so the flag stays low
                if (origin_seen && !(homing_cmd && internal_position_mode)) begin
                    home_nxt = SSOF_HM_DONE;
                end
            end
            SSOF_HM_DONE: begin
                // a new command outranks an overflow; both leave the flag low
                if (homing_cmd && internal_position_mode) begin
                    home_nxt = SSOF_HM_RUN;
                end else if (position_overflow) begin
                    home_nxt = SSOF_HM_NOT;
                end
            end
            default: home_nxt = SSOF_HM_NOT;
        endcase
    end

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            home_r <= SSOF_HM_NOT;
        end else begin
            home_r <= home_nxt;
        end
    end

    // ----------------------------------------
    // overload alarm latch
    // ----------------------------------------
    logic alarm_r;
    logic alarm_nxt;

    // a new overload beyond the limit wins over a reset in the same cycle
    assign alarm_nxt = ovl.over_permit || (alarm_r && !alarm_reset);

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            alarm_r <= 1'b0;
        end else begin
            alarm_r <= alarm_nxt;
        end
    end

    // ----------------------------------------
    // flag outputs
    // ----------------------------------------
    logic home_f;
    logic caut_f;
    logic warn_f;
    logic overrun_f;
    logic fault_f;

    assign home_f = (home_nxt == SSOF_HM_DONE) && internal_position_mode;
    assign caut_f = ovl.over_warn && internal_position_mode;
    assign warn_f = reverse_limit_err || forward_limit_err || emergency_stop
                    || serial_link_err || undervoltage;
    assign overrun_f = position_overflow;
    // caution faults are kept off the fault flag
    assign fault_f = alarm_nxt || other_fault;

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            homing_done_out <= 1'b0;
            overload_caution_out <= 1'b0;
            servo_caution_out <= 1'b0;
            position_cmd_overrun_out <= 1'b0;
            servo_fault_out <= 1'b0;
            overload_alarm_code <= 8'h00;
            func_out <= 1'b0;
        end else begin
            homing_done_out <= home_f;
            overload_caution_out <= caut_f;
            servo_caution_out <= warn_f;
            position_cmd_overrun_out <= overrun_f;
            servo_fault_out <= fault_f;
            overload_alarm_code <= alarm_nxt ? `SSOF_ALARM_CODE : 8'h00;
            func_out <= ssof_pick(out_func_sel, home_f, caut_f, warn_f, overrun_f, fault_f);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_HOME_DROP: assert property (@(posedge clk) disable iff (!rst_s_n)
        homing_cmd && internal_position_mode |=> !homing_done_out)
        else $error("homing flag did not drop on homing command");
    AST_HOME_HOLD: assert property (@(posedge clk) disable iff (!rst_s_n)
        homing_done_out && !position_overflow && !homing_cmd && internal_position_mode
        |=> homing_done_out)
        else $error("homing flag dropped without overflow");
    AST_HOME_SET: assert property (@(posedge clk) disable iff (!rst_s_n)
        home_r == SSOF_HM_RUN && origin_seen && internal_position_mode && !homing_cmd
        |=> homing_done_out && (func_out || $past(out_func_sel) != `SSOF_FN_HOME))
        else $error("origin detection did not set homing flag");
    AST_HOME_POWERUP: assert property (@(posedge clk) disable iff (!rst_s_n)
        $rose(rst_s_n) |-> !homing_done_out)
        else $error("homing flag high after power-up");
    AST_CAUTION: assert property (@(posedge clk) disable iff (!rst_s_n)
        (emergency_stop || undervoltage || serial_link_err) |=> servo_caution_out)
        else $error("caution flag missing on fault");
    AST_CAUTION_NOT_FAULT: assert property (@(posedge clk) disable iff (!rst_s_n)
        !alarm_r && !ovl.over_permit && !other_fault && reverse_limit_err
        |=> !servo_fault_out ##0 servo_caution_out)
        else $error("limit fault went straight to servo fault");
    AST_OVL_ALARM: assert property (@(posedge clk) disable iff (!rst_s_n)
        ovl.over_permit |=> servo_fault_out && overload_alarm_code == 8'h06)
        else $error("overload alarm not shown");
    AST_OVL_CAUTION: assert property (@(posedge clk) disable iff (!rst_s_n)
        ovl.over_warn && internal_position_mode |=> overload_caution_out)
        else $error("overload caution flag missing");
    AST_OVERRUN: assert property (@(posedge clk) disable iff (!rst_s_n)
        position_overflow |=> position_cmd_overrun_out)
        else $error("overflow flag missing");
    AST_MODE_GATE: assert property (@(posedge clk) disable iff (!rst_s_n)
        !internal_position_mode |=> !homing_done_out && !overload_caution_out)
        else $error("position mode flag high outside position mode");
endmodule
`default_nettype wire

// ===== ssof_defs.svh
// How it works
// - with output code 0x09 selected in internal position mode, homing-done rises when the origin sensor is detected.
// - from power-up the homing-done flag reads low until homing completes.
// - homing-done stays high while running in internal position mode; only a position overflow or a new homing command clears it.
// - a homing command in internal position mode drops the flag until homing finishes.
// - caution time is permissible overload time times the caution percentage.
// - in internal position mode, overload-caution flag rises when continuous overload time exceeds the caution time.
// - continuous overload beyond the permissible time raises the alarm and shows its code.
// - the overload alarm drives the servo-fault flag.
// - code 0x11 flag is high while limit, stop, link or undervoltage fault present.
// - code 0x12 flag is high while a position command overflow is detected.
// - limit, stop, link and undervoltage faults raise caution, not servo-fault.
`ifndef SSOF_DEFS_SVH
`define SSOF_DEFS_SVH

// ----------------------------------------
// output function codes
// ----------------------------------------
`define SSOF_FN_HOME 8'h09
`define SSOF_FN_CAUTION 8'h10
`define SSOF_FN_WARN 8'h11
`define SSOF_FN_OVERRUN 8'h12
`define SSOF_FN_FAULT 8'h07

// ----------------------------------------
// overload figures
// ----------------------------------------
`define SSOF_PERCENT_DIV 24'h000064
`define SSOF_ALARM_CODE 8'h06
`define SSOF_ACC_MAX 18'h3FFFF

// ----------------------------------------
// timing
// ----------------------------------------
`define SSOF_CLK_PERIOD_NS 10
`define SSOF_TICK_TIME_NS 1000000
`define SSOF_TICK_CYCLES (`SSOF_TICK_TIME_NS / `SSOF_CLK_PERIOD_NS)

`endif

// ===== ssof_pkg.sv
package ssof_pkg;
    typedef enum logic [2:0] {
        SSOF_HM_NOT  = 3'b001,
        SSOF_HM_RUN  = 3'b010,
        SSOF_HM_DONE = 3'b100
    } ssof_home_type;
endpackage

// ===== ssof_ovl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssof_ovl_if;
    logic overload_active;
    logic [15:0] permit_ms;
    logic [7:0] percent;
    logic over_warn;
    logic over_permit;
    modport timer (input overload_active, input permit_ms, input percent,
                   output over_warn, output over_permit);
    modport core (output overload_active, output permit_ms, output percent,
                  input over_warn, input over_permit);
endinterface
`default_nettype wire

// ===== ssof_ovl_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssof_defs.svh"
module ssof_ovl_timer
    import ssof_pkg::*;
#(
    parameter int TICK_CYCLES = `SSOF_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_s_n,
    ssof_ovl_if.timer ovl
);
    // ----------------------------------------
    // caution time arithmetic
    // ----------------------------------------
    function automatic logic [17:0] ssof_scale(input logic [15:0] p, input logic [7:0] pc);
        logic [23:0] prod;
        prod = 24'(p) * 24'(pc);
        return 18'(prod / `SSOF_PERCENT_DIV);
    endfunction

    logic [16:0] pre_r;
    logic tick_r;
    logic [17:0] acc_r;
    logic [17:0] warn_ms;
    logic warn_r;
    logic permit_r;

    // ----------------------------------------
    // millisecond prescaler
    // ----------------------------------------
    // free running so a fresh overload may gain up to one tick of time
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pre_r <= 17'h00000;
            tick_r <= 1'b0;
        end else if (pre_r == 17'(TICK_CYCLES - 1)) begin
            pre_r <= 17'h00000;
            tick_r <= 1'b1;
        end else begin
            pre_r <= pre_r + 17'h00001;
            tick_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // continuous overload accumulator
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            acc_r <= 18'h00000;
        end else if (!ovl.overload_active) begin
            acc_r <= 18'h00000;
        end else if (tick_r && acc_r != `SSOF_ACC_MAX) begin
            acc_r <= acc_r + 18'h00001;
        end
    end

    assign warn_ms = ssof_scale(ovl.permit_ms, ovl.percent);

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            warn_r <= 1'b0;
            permit_r <= 1'b0;
        end else begin
            warn_r <= ovl.overload_active && (acc_r > warn_ms);
            permit_r <= ovl.overload_active && (acc_r > 18'(ovl.permit_ms));
        end
    end

    assign ovl.over_warn = warn_r;
    assign ovl.over_permit = permit_r;

    AST_ACC_RESTART: assert property (@(posedge clk) disable iff (!rst_s_n)
        !ovl.overload_active |=> acc_r == 18'h00000 && !ovl.over_warn)
        else $error("overload time not restarted");
    AST_PERMIT_ABOVE_WARN: assert property (@(posedge clk) disable iff (!rst_s_n)
        ovl.percent <= 8'h64 && ovl.over_permit && $stable(ovl.permit_ms)
        && $stable(ovl.percent) |-> ovl.over_warn)
        else $error("permit time passed before caution time");
endmodule
`default_nettype wire

// ===== ssof_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far side: controller sampling the discrete outputs
// ----------------------------------------
module ssof_ctrl_model (
    input wire logic clk,
    input wire logic [4:0] flags,
    input wire logic func_in,
    output logic [5:0] seen
);
    // plain edge sampling, no debounce, so it sees every level change a cycle late
    always_ff @(posedge clk) begin
        seen <= {func_in, flags};
    end
endmodule
`default_nettype wire

// ===== ssof_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ssof_tb_top;
    localparam int TICK = 4;
    logic clk, rst_n, mode, origin, hcmd, povf, ovl, other, arst;
    logic [15:0] permit;
    logic [7:0] pct, sel, code;
    logic [4:0] lim;
    logic hd, oc, sc, po, sf, fo;
    logic [5:0] seen;
    int error_cnt, num_checks, thr, n;

    ssof_top #(.TICK_CYCLES(TICK)) i_dut (.clk(clk), .rst_n(rst_n),
        .internal_position_mode(mode), .origin_sensor_input(origin), .homing_cmd(hcmd),
        .position_overflow(povf), .overload_active(ovl), .overload_permit_ms(permit),
        .overload_caution_percent(pct), .reverse_limit_err(lim[0]),
        .forward_limit_err(lim[1]), .emergency_stop(lim[2]), .serial_link_err(lim[3]),
        .undervoltage(lim[4]), .other_fault(other), .alarm_reset(arst),
        .out_func_sel(sel), .homing_done_out(hd), .overload_caution_out(oc),
        .servo_caution_out(sc), .position_cmd_overrun_out(po), .servo_fault_out(sf),
        .overload_alarm_code(code), .func_out(fo));

    ssof_ctrl_model i_ctrl (.clk(clk), .flags({sf, po, sc, oc, hd}), .func_in(fo),
        .seen(seen));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic int caution_thr(input int p, input int c);
        return p * c / 100;
    endfunction

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic test_done;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    // generous: the whole run needs under 150 cycles
    initial begin
        #20000;
        error_cnt++;
        test_done();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        error_cnt = 0;
        num_checks = 0;
        {mode, origin, hcmd, povf, ovl, other, arst} = '0;
        lim = '0;
        permit = '0;
        pct = '0;
        sel = '0;
        rst_n = 0;
        n = $urandom(63855);
        cyc(2);
        rst_n = 1;
        cyc(3);
        chk(hd, 0);
        mode = 1;
        hcmd = 1;
        cyc(1);
        hcmd = 0;
        cyc(2);
        chk(hd, 0);
        origin = 1;
        cyc(2);
        chk(hd, 1);
        origin = 0;
        sel = 8'h09;
        cyc(5);
        chk(hd, 1);
        chk(seen[5], 1);
        mode = 0;
        cyc(2);
        chk(hd, 0);
        mode = 1;
        cyc(2);
        chk(hd, 1);
        hcmd = 1;
        cyc(1);
        hcmd = 0;
        cyc(1);
        chk(hd, 0);
        origin = 1;
        cyc(2);
        chk(hd, 1);
        povf = 1;
        sel = 8'h12;
        cyc(2);
        chk(hd, 0);
        chk(po, 1);
        chk(seen[5], 1);
        povf = 0;
        origin = 0;
        cyc(2);
        chk(po, 0);
        for (int i = 0; i < 5; i++) begin
            lim = 5'h01 << i;
            cyc(2);
            chk(sc, 1);
            chk(sf, 0);
        end
        sel = 8'h11;
        cyc(2);
        chk(seen[5], 1);
        chk(seen[4:0], 5'h04);
        repeat (6) begin
            lim = 5'($urandom);
            cyc(2);
            chk(sc, {7'h00, |lim});
        end
        lim = '0;
        other = 1;
        sel = 8'h07;
        cyc(3);
        chk(sf, 1);
        chk(seen[5], 1);
        other = 0;
        sel = 8'h03;
        cyc(3);
        chk(seen[5], 0);
        // overload: random permit and percentage below 100 so caution comes first
        permit = 16'($urandom_range(15, 8));
        pct = 8'($urandom_range(90, 30));
        thr = caution_thr(permit, pct);
        sel = 8'h10;
        ovl = 1;
        cyc(thr * TICK + 2);
        chk(oc, 0);
        n = 0;
        while (oc !== 1'b1 && n < 3 * TICK) begin
            cyc(1);
            n++;
        end
        chk(oc, 1);
        chk(sf, 0);
        n = 0;
        while (sf !== 1'b1 && n < (permit - thr + 2) * TICK) begin
            cyc(1);
            n++;
        end
        chk(sf, 1);
        chk(code, 8'h06);
        chk(seen[5], 1);
        ovl = 0;
        cyc(2);
        chk(sf, 1);
        chk(code, 8'h06);
        arst = 1;
        cyc(2);
        arst = 0;
        cyc(1);
        chk(sf, 0);
        chk(code, 8'h00);
        chk(oc, 0);
        test_done();
    end
endmodule
`default_nettype wire
